// ===== src/aotr_consts.svh
`ifndef AOTR_CONSTS_SVH
`define AOTR_CONSTS_SVH

// Byte addresses of the trim registers
`define AOTR_CORE3_OFFSET_INPUT_C 12'h338
`define AOTR_CORE3_OFFSET_INPUT_D 12'h33a
`define AOTR_CORE4_OFFSET         12'h33c
`define AOTR_CORE5_OFFSET         12'h33e
`define AOTR_CORE0_FINE_GAIN      12'h360
`define AOTR_CORE1_FINE_GAIN      12'h361
`define AOTR_CORE2_FINE_GAIN_A    12'h362

// Register widths and field layout
`define AOTR_OFFSET_REG_W 16
`define AOTR_GAIN_REG_W   8
`define AOTR_OFFSET_MSB   11
`define AOTR_GAIN_MSB     4

// Reset values before the fuse load
`define AOTR_OFFSET_RESET 16'h0000
`define AOTR_GAIN_RESET   8'h00

`endif

// ===== src/aotr_pkg.sv
package aotr_pkg;
  typedef logic [11:0] aotr_addr_t;
  typedef logic [15:0] aotr_data_t;
  typedef logic [11:0] aotr_offset_t;
  typedef logic [4:0]  aotr_gain_t;
endpackage : aotr_pkg

// ===== src/aotr_trim_cell.sv
`timescale 1ns/100ps
`default_nettype none
module aotr_trim_cell #(
  parameter int         W         = 16,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clock,      // System clock
  input  wire logic         reset,      // Synchronous reset
  input  wire logic         load,       // Fuse load pulse
  input  wire logic [W-1:0] load_value, // Fuse default
  input  wire logic         we,         // Software write
  input  wire logic [W-1:0] wdata,      // Software write data
  output logic      [W-1:0] q           // Stored value
);
  // Software write beats a fuse load in the same cycle
  wire logic [W-1:0] next_q = we ? wdata : (load ? load_value : q);

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= RESET_VAL;
    end else begin
      q <= next_q;
    end
  end
endmodule : aotr_trim_cell
`default_nettype wire

// ===== src/aotr_trim_regs.sv
// Contract
// - Offset registers apply low 12 bits
// - Core 3 applies C or D offset
// - Trim values load from fuse defaults
// - Gain registers apply low 5 bits
// - Core 2 has dedicated input A gain
// - Offset value is unsigned binary
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "aotr_consts.svh"
module aotr_trim_regs (
  input  wire logic                clock,                // 100 MHz clock
  input  wire logic                reset,                // Synchronous, active high
  input  wire aotr_pkg::aotr_addr_t reg_addr,            // Register byte address
  input  wire aotr_pkg::aotr_data_t reg_wdata,           // Write data
  input  wire logic                reg_write,            // Write strobe
  input  wire logic                reg_read,             // Read strobe
  output aotr_pkg::aotr_data_t     reg_rdata,            // Read data, cycle after strobe
  input  wire logic                fuse_load,            // Reload from fuse storage
  input  wire logic [15:0]         fuse_core3_offset_c,  // Fuse default
  input  wire logic [15:0]         fuse_core3_offset_d,  // Fuse default
  input  wire logic [15:0]         fuse_core4_offset,    // Fuse default
  input  wire logic [15:0]         fuse_core5_offset,    // Fuse default
  input  wire logic [7:0]          fuse_core0_gain,      // Fuse default
  input  wire logic [7:0]          fuse_core1_gain,      // Fuse default
  input  wire logic [7:0]          fuse_core2_gain_a,    // Fuse default
  input  wire logic                core3_sample_d,       // Core 3 samples input_pair_d
  output aotr_pkg::aotr_offset_t   core3_offset_applied, // Core 3 offset in use
  output aotr_pkg::aotr_offset_t   core4_offset_applied, // Core 4 offset
  output aotr_pkg::aotr_offset_t   core5_offset_applied, // Core 5 offset
  output aotr_pkg::aotr_gain_t     core0_gain_applied,   // Core 0 fine gain
  output aotr_pkg::aotr_gain_t     core1_gain_applied,   // Core 1 fine gain
  output aotr_pkg::aotr_gain_t     core2_gain_a_applied  // Core 2 gain on input_pair_a
);
  import aotr_pkg::*;

  localparam int NREG = 7;
  localparam int NOFS = 4;
  // Address of each trim register, in storage order
  localparam aotr_addr_t REG_ADDR [NREG] = '{
    `AOTR_CORE3_OFFSET_INPUT_C,
    `AOTR_CORE3_OFFSET_INPUT_D,
    `AOTR_CORE4_OFFSET,
    `AOTR_CORE5_OFFSET,
    `AOTR_CORE0_FINE_GAIN,
    `AOTR_CORE1_FINE_GAIN,
    `AOTR_CORE2_FINE_GAIN_A
  };

  wire aotr_data_t fuse_value [NREG];
  aotr_data_t      stored     [NREG];
  wire logic [NREG-1:0] hit;
  logic            boot_load;
  wire logic       load_now;
  wire logic [NREG-1:0] write_hit;
  wire aotr_data_t read_term  [NREG];
  wire aotr_data_t read_mux;
  wire aotr_data_t read_value;

  // Offset registers take the whole fuse word
  assign fuse_value[0] = fuse_core3_offset_c;
  assign fuse_value[1] = fuse_core3_offset_d;
  assign fuse_value[2] = fuse_core4_offset;
  assign fuse_value[3] = fuse_core5_offset;
  // Gain registers take the low byte; the upper byte reads as zero
  assign fuse_value[4] = {8'h00, fuse_core0_gain};
  assign fuse_value[5] = {8'h00, fuse_core1_gain};
  assign fuse_value[6] = {8'h00, fuse_core2_gain_a};

  // Fuse contents are sampled after reset release, not during reset
  assign load_now = boot_load | fuse_load;

  always_ff @(posedge clock) begin
    if (reset) begin
      boot_load <= 1'b1;
    end else begin
      boot_load <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NREG; i++) begin : g_reg
      localparam int W = (i < NOFS) ? `AOTR_OFFSET_REG_W : `AOTR_GAIN_REG_W;
      localparam logic [W-1:0] RV = (i < NOFS) ? W'(`AOTR_OFFSET_RESET) : W'(`AOTR_GAIN_RESET);
      wire logic [W-1:0] q;
      assign hit[i]       = (reg_addr == REG_ADDR[i]);
      assign write_hit[i] = reg_write & hit[i];
      assign read_term[i] = hit[i] ? stored[i] : 16'h0000;
      // Reserved bits are stored as written; software keeps them zero
      aotr_trim_cell #(.W(W), .RESET_VAL(RV)) u_cell (
        .clock      (clock),
        .reset      (reset),
        .load       (load_now),
        .load_value (fuse_value[i][W-1:0]),
        .we         (write_hit[i]),
        .wdata      (reg_wdata[W-1:0]),
        .q          (q)
      );
      if (W < 16) begin : g_pad
        assign stored[i] = {{(16-W){1'b0}}, q};
      end else begin : g_full
        assign stored[i] = q;
      end
    end
  endgenerate

  // Read select; unmapped addresses match no term and read as zero
  assign read_mux = read_term[0]
                  | read_term[1]
                  | read_term[2]
                  | read_term[3]
                  | read_term[4]
                  | read_term[5]
                  | read_term[6];
  // Data stands for one cycle only, so an idle bus reads zero
  assign read_value = reg_read ? read_mux : 16'h0000;

  // Values each converter core consumes, taken from the low field only
  wire aotr_offset_t core3_offset_c = stored[0][`AOTR_OFFSET_MSB:0];
  wire aotr_offset_t core3_offset_d = stored[1][`AOTR_OFFSET_MSB:0];
  wire aotr_offset_t core4_offset   = stored[2][`AOTR_OFFSET_MSB:0];
  wire aotr_offset_t core5_offset   = stored[3][`AOTR_OFFSET_MSB:0];
  wire aotr_gain_t   core0_gain     = stored[4][`AOTR_GAIN_MSB:0];
  wire aotr_gain_t   core1_gain     = stored[5][`AOTR_GAIN_MSB:0];
  wire aotr_gain_t   core2_gain_a   = stored[6][`AOTR_GAIN_MSB:0];

  // Core 3 choice is registered so the output comes from a flop
  wire aotr_offset_t next_core3 = core3_sample_d ? core3_offset_d : core3_offset_c;

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= read_value;
    end
  end

  // Offsets pass on as unsigned codes, no sign extension
  always_ff @(posedge clock) begin
    if (reset) begin
      core3_offset_applied <= 12'h000;
    end else begin
      core3_offset_applied <= next_core3;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core4_offset_applied <= 12'h000;
    end else begin
      core4_offset_applied <= core4_offset;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core5_offset_applied <= 12'h000;
    end else begin
      core5_offset_applied <= core5_offset;
    end
  end

  // Gains pass the low five bits; reserved bits never reach a core
  always_ff @(posedge clock) begin
    if (reset) begin
      core0_gain_applied <= 5'h00;
    end else begin
      core0_gain_applied <= core0_gain;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core1_gain_applied <= 5'h00;
    end else begin
      core1_gain_applied <= core1_gain;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core2_gain_a_applied <= 5'h00;
    end else begin
      core2_gain_a_applied <= core2_gain_a;
    end
  end
endmodule : aotr_trim_regs
`default_nettype wire

// ===== test/aotr_trim_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module aotr_trim_assertions (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic [11:0] reg_addr, // Address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic fuse_load, // Reload
  input wire logic [15:0] fuse_core5_offset, // Fuse value
  input wire logic core3_sample_d, // Core 3 select
  input wire logic [11:0] core3_offset_applied, // Applied
  input wire logic [11:0] core4_offset_applied, // Applied
  input wire logic [11:0] core5_offset_applied, // Applied
  input wire logic [4:0] core0_gain_applied, // Applied
  input wire logic [4:0] core2_gain_a_applied // Applied
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence wr(a); reg_write && reg_addr == a; endsequence
  // Applied values trail the store by one flop, so a later write cannot mask these
  a_core4_applied: assert property (wr(12'h33c) |-> ##2
    core4_offset_applied == $past(reg_wdata[11:0], 2)) else $error("core4 offset");
  a_core3_input_c: assert property (wr(12'h338) ##1 !core3_sample_d |=>
    core3_offset_applied == $past(reg_wdata[11:0], 2)) else $error("core3 c offset");
  a_core3_input_d: assert property (wr(12'h33a) ##1 core3_sample_d |=>
    core3_offset_applied == $past(reg_wdata[11:0], 2)) else $error("core3 d offset");
  a_core0_gain: assert property (wr(12'h360) |-> ##2
    core0_gain_applied == $past(reg_wdata[4:0], 2)) else $error("core0 gain");
  a_core2_gain_a: assert property (wr(12'h362) |-> ##2
    core2_gain_a_applied == $past(reg_wdata[4:0], 2)) else $error("core2 gain");
  a_fuse_reload: assert property (fuse_load && !(reg_write && reg_addr == 12'h33e) |-> ##2
    core5_offset_applied == $past(fuse_core5_offset[11:0], 2)) else $error("fuse reload");
  a_read_back: assert property (wr(12'h33c) ##1 (reg_read && reg_addr == 12'h33c) |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("read back");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000) else $error("rdata idle");
endmodule : aotr_trim_assertions
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 0, reset = 1, reg_write = 0, reg_read = 0, fuse_load = 0, sel = 0;
  logic [11:0] reg_addr = 0, o3, o4, o5;
  logic [15:0] reg_wdata = 0, reg_rdata, f[7], m[8] = '{default: 0};
  logic [4:0] g0, g1, g2;
  logic [11:0] ad[8] = '{12'h338, 12'h33a, 12'h33c, 12'h33e, 12'h360, 12'h361, 12'h362, 12'h340};
  int seed = 32'hdb98d42c, fails = 0, n_checks = 0, i;
  logic [15:0] rd_exp = 16'h0000;
  logic rd_due = 1'b0;
  aotr_trim_regs DUT (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .fuse_load, .fuse_core3_offset_c(f[0]), .fuse_core3_offset_d(f[1]), .fuse_core4_offset(f[2]),
    .fuse_core5_offset(f[3]), .fuse_core0_gain(f[4][7:0]), .fuse_core1_gain(f[5][7:0]),
    .fuse_core2_gain_a(f[6][7:0]), .core3_sample_d(sel), .core3_offset_applied(o3),
    .core4_offset_applied(o4), .core5_offset_applied(o5), .core0_gain_applied(g0),
    .core1_gain_applied(g1), .core2_gain_a_applied(g2));
  task automatic chk(input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [15:0] want(input int r);
    return r > 3 ? {8'h00, m[r][7:0]} : m[r];
  endfunction : want
  task automatic fuse_new;
    foreach (f[j]) f[j] = 16'($random(seed));
    m[0:6] = f;
  endtask : fuse_new
  // Read data stands only in the cycle after its strobe and is zero otherwise
  task automatic tick;
    @(posedge clock);
    chk(reg_rdata, rd_due ? rd_exp : 16'h0000);
    rd_due = 0;
  endtask : tick
  // Bus tasks start right after an edge and leave the strobe for the next call
  task automatic wr(input int r, input logic [15:0] d);
    // No calibration runs in this bench, so offset access is always allowed
    reg_write <= 1;
    reg_read <= 0;
    reg_addr <= ad[r];
    reg_wdata <= d;
    sel <= 1'($random(seed));
    tick();
    m[r] = r < 7 ? d : 16'h0;
  endtask : wr
  task automatic rd(input int r);
    reg_read <= 1;
    reg_write <= 0;
    reg_addr <= ad[r];
    tick();
    rd_exp = want(r);
    rd_due = 1;
  endtask : rd
  task automatic outs(input logic s);
    reg_write <= 0;
    reg_read <= 0;
    sel <= s;
    repeat (2) tick();
    chk(16'(o3), 16'(s ? m[1][11:0] : m[0][11:0]));
    chk(16'(o4), 16'(m[2][11:0]));
    chk(16'(o5), 16'(m[3][11:0]));
    chk(16'(g0), 16'(m[4][4:0]));
    chk(16'(g1), 16'(m[5][4:0]));
    chk(16'(g2), 16'(m[6][4:0]));
  endtask : outs
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial forever #5 clock = ~clock;
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    conclude();
  end
  initial begin
    fuse_new();
    repeat (12) @(posedge clock);
    reset <= 0;
    // The first edge after release copies the fuses; requests wait for it
    tick();
    for (i = 0; i < 8; i++) rd(i);
    outs(0);
    $display("fuse defaults done");
    wr(2, 16'h0abc);
    rd(2);
    repeat (40) begin
      i = {$random(seed)} % 7;
      wr(i, 16'($random(seed)) & (i > 3 ? 16'h1f : 16'hfff));
      rd(i);
    end
    outs(1);
    // Unmapped write must leave every register alone
    wr(7, 16'hffff);
    for (i = 0; i < 8; i++) rd(i);
    $display("random writes done");
    fuse_new();
    reg_read <= 0;
    fuse_load <= 1;
    tick();
    fuse_load <= 0;
    for (i = 0; i < 7; i++) rd(i);
    outs(0);
    $display("fuse reload done");
    conclude();
  end
endmodule : tb
bind aotr_trim_regs aotr_trim_assertions u_chk (.clock, .reset, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .fuse_load, .fuse_core5_offset, .core3_sample_d, .core3_offset_applied,
  .core4_offset_applied, .core5_offset_applied, .core0_gain_applied, .core2_gain_a_applied);
`default_nettype wire
